// File: logic/srs_cfg.svh
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH

// clock rate
`define SRS_CLK_MHZ 200

// power-on reset hold after keep-alive regulation
`define SRS_POR_TIME_MS 10
`define SRS_POR_CYC (`SRS_POR_TIME_MS * 1000 * `SRS_CLK_MHZ)

// fault persistence filter
`define SRS_FILTER_TIME_US 20
`define SRS_FILTER_CYC (`SRS_FILTER_TIME_US * `SRS_CLK_MHZ)

// early-to-hard reset stagger, rounded up to whole cycles
`define SRS_STAGGER_TIME_NS 700
`define SRS_STAGGER_CYC ((`SRS_STAGGER_TIME_NS * `SRS_CLK_MHZ + 999) / 1000)

// least duration of a whole power-up or power-down
`define SRS_SEQ_TIME_US 800
`define SRS_SEQ_CYC (`SRS_SEQ_TIME_US * `SRS_CLK_MHZ)

// reference ramp
`define SRS_STEP_COUNT 6
`define SRS_LEVEL_W 3

// bit positions in the synchronised pin vector
`define SRS_IN_KA_OK 0
`define SRS_IN_HIGH_OK 1
`define SRS_IN_MID_OK 2
`define SRS_IN_CORE_OK 3
`define SRS_IN_STEP_MET 4
`define SRS_IN_IGN 7
`define SRS_IN_HOLD 8
`define SRS_IN_SLEEP_N 9
`define SRS_IN_TIMER 10
`define SRS_IN_W 11

`endif

// File: logic/srs_persist_filter.sv
`timescale 1ns/1ps
`include "srs_cfg.svh"

// reports a fault only after the bad level persists beyond CYCLES
module srs_persist_filter #(
  parameter int CYCLES = `SRS_FILTER_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_enable,
  input wire logic i_bad,
  output logic o_fault
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt;
  wire watching = i_enable && i_bad;
  wire expired = (cnt == CW'(CYCLES));

  // count consecutive bad cycles, flag on the one after CYCLES
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= '0;
      o_fault <= 1'b0;
    end else if (!watching) begin
      cnt <= '0;
      o_fault <= 1'b0;
    end else begin
      if (!expired) cnt <= CW'(cnt + 1'b1);
      o_fault <= expired;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_filter_persist: assert property ($rose(o_fault) |-> $past(cnt) == CW'(CYCLES) && $past(i_bad))
    else $error("fault flagged before persistence time");
  a_filter_drop: assert property (!i_bad |=> !o_fault)
    else $error("fault held after bad level went away");
endmodule : srs_persist_filter

// File: logic/srs_pkg.sv
package srs_pkg;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_OFF     = 6'h01,
    ST_UP      = 6'h02,
    ST_HOLDOFF = 6'h04,
    ST_RUN     = 6'h08,
    ST_STAGGER = 6'h10,
    ST_DOWN    = 6'h20
  } srs_state_e;

  // reference ramp command, one-hot
  typedef enum logic [2:0] {
    DIR_HOLD = 3'h1,
    DIR_UP   = 3'h2,
    DIR_DOWN = 3'h4
  } srs_dir_e;

endpackage : srs_pkg

// File: logic/srs_ramp_if.sv
`timescale 1ns/1ps
`include "srs_cfg.svh"

// command and status between sequencer and reference stepper
interface srs_ramp_if #(parameter int LEVEL_W = `SRS_LEVEL_W);
  srs_pkg::srs_dir_e dir;
  logic step_met;
  logic [LEVEL_W-1:0] level;

  modport ctrl (output dir, output step_met, input level);
  modport ramp (input dir, input step_met, output level);
endinterface : srs_ramp_if

// File: logic/srs_ramp_stepper.sv
`timescale 1ns/1ps
`include "srs_cfg.svh"

// steps the main-supply reference between zero and STEPS
module srs_ramp_stepper #(
  parameter int STEPS = `SRS_STEP_COUNT,
  parameter int SEQ_CYC = `SRS_SEQ_CYC,
  parameter int LEVEL_W = `SRS_LEVEL_W
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  srs_ramp_if.ramp ramp
);
  localparam int STEP_CYC = (SEQ_CYC + STEPS - 1) / STEPS;
  localparam int TW = $clog2(STEP_CYC + 1);

  logic [TW-1:0] dwell;
  logic [LEVEL_W-1:0] level;

  // step decode
  wire going_up = (ramp.dir == srs_pkg::DIR_UP) && (level != LEVEL_W'(STEPS));
  wire going_dn = (ramp.dir == srs_pkg::DIR_DOWN) && (level != '0);
  wire dwell_done = (dwell == TW'(STEP_CYC - 1));
  wire advance = (going_up || going_dn) && dwell_done && ramp.step_met;

  assign ramp.level = level;

  // least dwell per step keeps a whole ramp at or above the sequence time
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dwell <= '0;
    end else if (!(going_up || going_dn) || advance) begin
      dwell <= '0;
    end else if (!dwell_done) begin
      dwell <= TW'(dwell + 1'b1);
    end
  end

  // seven discrete reference levels, zero to STEPS
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      level <= '0;
    end else if (advance) begin
      level <= going_up ? LEVEL_W'(level + 1'b1) : LEVEL_W'(level - 1'b1);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_step_gated: assert property (level != $past(level) |-> $past(dwell_done) && $past(ramp.step_met))
    else $error("reference moved without dwell and level met");
  a_step_range: assert property (level <= LEVEL_W'(STEPS) && (level == $past(level) + 1'b1 ||
      level == $past(level) - 1'b1 || level == $past(level)))
    else $error("reference left its six steps");
endmodule : srs_ramp_stepper

// File: logic/srs_supply_sequencer.sv
`timescale 1ns/1ps
`include "srs_cfg.svh"

module srs_supply_sequencer #(
  parameter int POR_CYC = `SRS_POR_CYC,
  parameter int SEQ_CYC = `SRS_SEQ_CYC,
  parameter int FILTER_CYC = `SRS_FILTER_CYC,
  parameter int STAGGER_CYC = `SRS_STAGGER_CYC,
  parameter int STEPS = `SRS_STEP_COUNT
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_keep_alive_supply_ok,
  input wire logic i_high_supply_ok,
  input wire logic i_mid_supply_ok,
  input wire logic i_core_supply_ok,
  input wire logic [2:0] i_step_met,
  input wire logic i_ignition_input,
  input wire logic i_regulator_hold,
  input wire logic i_sleep_n,
  input wire logic i_reset_delay_timer,
  output logic o_power_on_reset_n_o,
  output logic o_power_on_reset_n_oe,
  output logic o_early_reset_n_o,
  output logic o_early_reset_n_oe,
  output logic o_hard_reset_n_o,
  output logic o_hard_reset_n_oe,
  output logic [`SRS_LEVEL_W-1:0] o_ref_level,
  output logic o_main_enable,
  output logic o_aux_enable,
  output logic o_reset_delay_discharge,
  output logic o_sleeping
);
  localparam int LW = `SRS_LEVEL_W;
  localparam int PW = $clog2(POR_CYC + 1);
  localparam int SW = $clog2(STAGGER_CYC + 1);

  srs_pkg::srs_state_e state;
  srs_pkg::srs_state_e next_state;
  logic [`SRS_IN_W-1:0] pin_meta;
  logic [`SRS_IN_W-1:0] pin_sync;
  logic sleep_n_prev;
  logic sleep_req;
  logic quiet;
  logic next_quiet;
  logic early_low;
  logic hard_low;
  logic por_low;
  logic need_ign;
  logic [PW-1:0] por_cnt;
  logic [SW-1:0] stg_cnt;
  logic ka_fault;
  logic main_fault;
  logic main_en;
  logic aux_en;
  logic discharge;

  srs_ramp_if #(.LEVEL_W(LW)) ramp_bus ();

  // two-stage synchroniser for every pin input
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {i_reset_delay_timer, i_sleep_n, i_regulator_hold, i_ignition_input, i_step_met,
                   i_core_supply_ok, i_mid_supply_ok, i_high_supply_ok, i_keep_alive_supply_ok};
      pin_sync <= pin_meta;
    end
  end

  // named synchronised levels
  wire ka_ok = pin_sync[`SRS_IN_KA_OK];
  wire main_ok = pin_sync[`SRS_IN_HIGH_OK] && pin_sync[`SRS_IN_MID_OK] && pin_sync[`SRS_IN_CORE_OK];
  wire all_met = &pin_sync[`SRS_IN_STEP_MET +: 3];
  wire ign = pin_sync[`SRS_IN_IGN];
  wire hold = pin_sync[`SRS_IN_HOLD];
  wire sleep_n = pin_sync[`SRS_IN_SLEEP_N];
  wire timer_hit = pin_sync[`SRS_IN_TIMER]; // comparator above 2.5 V
  wire sleep_fall = sleep_n_prev && !sleep_n;

  // comparator already trips at 4% below nominal
  srs_persist_filter #(.CYCLES(FILTER_CYC)) u_ka_filter (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_enable(1'b1),
    .i_bad(!ka_ok),
    .o_fault(ka_fault)
  );

  // main supplies watched only once they should be regulating
  wire main_watch = (state == srs_pkg::ST_HOLDOFF) || (state == srs_pkg::ST_RUN);
  srs_persist_filter #(.CYCLES(FILTER_CYC)) u_main_filter (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_enable(main_watch),
    .i_bad(!main_ok),
    .o_fault(main_fault)
  );

  srs_ramp_stepper #(.STEPS(STEPS), .SEQ_CYC(SEQ_CYC), .LEVEL_W(LW)) u_stepper (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .ramp(ramp_bus)
  );

  // sleep request: falling edge sets, high level clears
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sleep_n_prev <= 1'b0;
      sleep_req <= 1'b0;
    end else begin
      sleep_n_prev <= sleep_n;
      if (sleep_fall) sleep_req <= 1'b1;
      else if (sleep_n) sleep_req <= 1'b0;
    end
  end

  // run request; hold keeps supplies after ignition drops
  // a short keep-alive dip stops nothing, only the filtered fault does
  wire run_ok = !ka_fault && (ign || hold) && !sleep_req;
  wire want_on = ka_ok && run_ok;
  wire stop_fault = ka_fault || main_fault;
  wire stop_req = stop_fault || !run_ok;
  wire quiet_stop = (state == srs_pkg::ST_RUN) && sleep_req && !stop_fault;
  wire at_top = (ramp_bus.level == LW'(STEPS));
  wire at_bottom = (ramp_bus.level == '0);

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      srs_pkg::ST_OFF: begin
        if (want_on) next_state = srs_pkg::ST_UP;
      end
      srs_pkg::ST_UP: begin
        if (stop_req) next_state = srs_pkg::ST_STAGGER;
        else if (at_top) next_state = srs_pkg::ST_HOLDOFF;
      end
      srs_pkg::ST_HOLDOFF: begin
        if (stop_req) next_state = srs_pkg::ST_STAGGER;
        else if (timer_hit) next_state = srs_pkg::ST_RUN;
      end
      srs_pkg::ST_RUN: begin
        if (quiet_stop) next_state = srs_pkg::ST_DOWN;
        else if (stop_req) next_state = srs_pkg::ST_STAGGER;
      end
      srs_pkg::ST_STAGGER: begin
        if (hard_low) next_state = srs_pkg::ST_DOWN;
      end
      srs_pkg::ST_DOWN: begin
        if (at_bottom) next_state = srs_pkg::ST_OFF;
      end
      default: next_state = srs_pkg::ST_OFF;
    endcase
  end

  // quiet sleep shutdown and early reset level
  assign next_quiet = quiet_stop || (quiet && sleep_req && !ka_fault);
  wire next_early_low = ka_fault || !(next_state == srs_pkg::ST_RUN || next_quiet);
  wire stg_done = (stg_cnt == SW'(STAGGER_CYC - 1));

  // state, early reset and staggered hard reset
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= srs_pkg::ST_OFF;
      quiet <= 1'b0;
      early_low <= 1'b1;
    end else begin
      state <= next_state;
      quiet <= next_quiet;
      early_low <= next_early_low;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hard_low <= 1'b1;
      stg_cnt <= '0;
    end else if (!next_early_low) begin
      hard_low <= 1'b0;
      stg_cnt <= '0;
    end else if (quiet && !ka_fault) begin
      hard_low <= 1'b1;
    end else if (early_low && !hard_low) begin
      hard_low <= stg_done;
      stg_cnt <= SW'(stg_cnt + 1'b1);
    end
  end

  // power-on reset timer, run only while keep-alive regulates
  wire por_run = por_low && ka_ok && !ka_fault && !need_ign;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      por_cnt <= '0;
      por_low <= 1'b1;
      need_ign <= 1'b0;
    end else begin
      por_cnt <= por_run ? PW'(por_cnt + 1'b1) : '0;
      if (ka_fault) por_low <= 1'b1;
      else if (por_run && por_cnt == PW'(POR_CYC - 1)) por_low <= 1'b0;
      if (ka_fault && !ign) need_ign <= 1'b1;
      else if (ign) need_ign <= 1'b0;
    end
  end

  // supply enables and timer discharge
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      main_en <= 1'b0;
      aux_en <= 1'b0;
      discharge <= 1'b1;
    end else begin
      main_en <= next_state != srs_pkg::ST_OFF;
      aux_en <= (next_state == srs_pkg::ST_HOLDOFF) || (next_state == srs_pkg::ST_RUN);
      discharge <= !((next_state == srs_pkg::ST_HOLDOFF) || (next_state == srs_pkg::ST_RUN));
    end
  end

  // ramp command follows the sequencer
  assign ramp_bus.dir = (state == srs_pkg::ST_UP) ? srs_pkg::DIR_UP :
                        (state == srs_pkg::ST_DOWN) ? srs_pkg::DIR_DOWN : srs_pkg::DIR_HOLD;
  assign ramp_bus.step_met = all_met;

  // open-drain pins only ever pull low
  assign o_power_on_reset_n_o = 1'b0;
  assign o_early_reset_n_o = 1'b0;
  assign o_hard_reset_n_o = 1'b0;
  assign o_power_on_reset_n_oe = por_low;
  assign o_early_reset_n_oe = early_low;
  assign o_hard_reset_n_oe = hard_low;
  assign o_ref_level = ramp_bus.level;
  assign o_main_enable = main_en;
  assign o_aux_enable = aux_en;
  assign o_reset_delay_discharge = discharge;
  assign o_sleeping = quiet;

  localparam int A_STG = STAGGER_CYC;
  localparam int A_STG_M1 = STAGGER_CYC - 1;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_early_falls;
    $rose(early_low) && !hard_low;
  endsequence

  sequence s_early_held;
    early_low && !ka_fault;
  endsequence

  a_hard_not_early: assert property (s_early_falls |-> ##A_STG_M1 !hard_low)
    else $error("hard reset fell before the stagger");
  a_hard_staggered: assert property (s_early_falls ##1 s_early_held |-> ##A_STG hard_low)
    else $error("hard reset missed its stagger");
  a_down_on_hard: assert property (state == srs_pkg::ST_STAGGER && hard_low |=> state == srs_pkg::ST_DOWN)
    else $error("power-down not started on hard reset");
  a_seq_resets_low: assert property ((state == srs_pkg::ST_UP || state == srs_pkg::ST_STAGGER ||
      (state == srs_pkg::ST_DOWN && !quiet)) |-> early_low)
    else $error("early reset released while sequencing");
  a_sleep_quiet: assert property (quiet && !ka_fault |-> !o_early_reset_n_oe && !o_hard_reset_n_oe)
    else $error("reset pulled during sleep power-down");
  a_run_timer: assert property ($rose(state == srs_pkg::ST_RUN) |-> $past(timer_hit) && !early_low)
    else $error("run entered without reset delay timer");
  a_ka_priority: assert property (ka_fault |=> por_low && early_low && state != srs_pkg::ST_RUN)
    else $error("keep-alive fault not handled first");
  a_por_timed: assert property ($fell(por_low) |-> $past(por_cnt) == PW'(POR_CYC - 1) && $past(ka_ok))
    else $error("power-on reset released early");
  a_por_wait_ign: assert property (need_ign && !ign |=> por_low && por_cnt == '0)
    else $error("power-on timer ran before ignition");
  a_up_needs_ka: assert property ($rose(state == srs_pkg::ST_UP) |-> $past(ka_ok) && !$past(ka_fault))
    else $error("power-up without keep-alive regulation");

  // sleep exit not caused by a keep-alive fault
  sequence s_quiet_ends;
    $fell(quiet) && !$past(ka_fault);
  endsequence

  a_sleep_exit: assert property (s_quiet_ends |-> early_low && hard_low)
    else $error("resets not both asserted on sleep exit");
  a_hard_within_early: assert property (hard_low |-> early_low)
    else $error("hard reset pulled while early reset released");
  a_ramp_in_seq: assert property ($changed(o_ref_level) |-> $past(ramp_bus.dir != srs_pkg::DIR_HOLD))
    else $error("reference moved outside sequencing");
endmodule : srs_supply_sequencer

// File: verif/srs_supply_model.sv
`timescale 1ns/1ps

// main supplies and reset delay timer as seen from the sequencer
module srs_supply_model #(
  parameter int TIMER_CYC = 15
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [2:0] i_ref_level,
  input wire logic i_main_enable,
  input wire logic i_discharge,
  input wire logic i_slow,
  input wire logic [2:0] i_bad,
  output logic [2:0] o_step_met,
  output logic o_high_ok,
  output logic o_mid_ok,
  output logic o_core_ok,
  output logic o_timer
);
  logic [2:0] last;
  int dwell;
  int rc;
  logic settled;

  // supplies settle some cycles after each reference step
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      last <= 3'h0;
      dwell <= 0;
      rc <= 0;
    end else begin
      last <= i_ref_level;
      dwell <= (last != i_ref_level) ? 0 : ((dwell < 40) ? dwell + 1 : dwell);
      rc <= i_discharge ? 0 : ((rc < TIMER_CYC) ? rc + 1 : rc);
    end
  end

  // step reached only after the lag; slow lag outlasts the step dwell
  assign settled = (last == i_ref_level) && (dwell >= (i_slow ? 24 : 1));
  assign o_step_met = {3{settled}};
  assign o_high_ok = i_main_enable & ~i_bad[0];
  assign o_mid_ok = i_main_enable & ~i_bad[1];
  assign o_core_ok = i_main_enable & ~i_bad[2];
  assign o_timer = (rc >= TIMER_CYC);
endmodule : srs_supply_model

// File: verif/test_srs_supply_sequencer.sv
`timescale 1ns/1ps

module test_srs_supply_sequencer;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic ka_ok = 1'b0;
  logic ign = 1'b0;
  logic hold = 1'b0;
  logic sleep_n = 1'b1;
  logic slow = 1'b0;
  logic [2:0] bad = 3'h0;
  logic [2:0] step_met;
  logic high_ok, mid_ok, core_ok, timer;
  logic por_o, por_oe, early_o, early_oe, hard_o, hard_oe;
  logic [2:0] level;
  logic main_en, aux_en, discharge, sleeping;
  logic power_on_reset_n, early_reset_n, hard_reset_n;
  int bad_count = 0;
  int num_checks = 0;
  int cnt;

  always #2.5 i_clk = ~i_clk;

  // pull-ups on the open-drain reset pins
  assign power_on_reset_n = por_oe ? por_o : 1'b1;
  assign early_reset_n = early_oe ? early_o : 1'b1;
  assign hard_reset_n = hard_oe ? hard_o : 1'b1;

  srs_supply_sequencer #(.POR_CYC(50), .SEQ_CYC(60), .FILTER_CYC(8), .STAGGER_CYC(4))
  srs_supply_sequencer_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_keep_alive_supply_ok(ka_ok),
    .i_high_supply_ok(high_ok), .i_mid_supply_ok(mid_ok), .i_core_supply_ok(core_ok),
    .i_step_met(step_met), .i_ignition_input(ign), .i_regulator_hold(hold),
    .i_sleep_n(sleep_n), .i_reset_delay_timer(timer),
    .o_power_on_reset_n_o(por_o), .o_power_on_reset_n_oe(por_oe),
    .o_early_reset_n_o(early_o), .o_early_reset_n_oe(early_oe),
    .o_hard_reset_n_o(hard_o), .o_hard_reset_n_oe(hard_oe),
    .o_ref_level(level), .o_main_enable(main_en), .o_aux_enable(aux_en),
    .o_reset_delay_discharge(discharge), .o_sleeping(sleeping)
  );

  srs_supply_model #(.TIMER_CYC(15)) srs_supply_model_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ref_level(level), .i_main_enable(main_en),
    .i_discharge(discharge), .i_slow(slow), .i_bad(bad), .o_step_met(step_met),
    .o_high_ok(high_ok), .o_mid_ok(mid_ok), .o_core_ok(core_ok), .o_timer(timer)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cycles

  function automatic logic met(input int sel);
    case (sel)
      0: met = (early_reset_n === 1'b1);
      1: met = (early_reset_n === 1'b0);
      2: met = (power_on_reset_n === 1'b1);
      3: met = (power_on_reset_n === 1'b0);
      4: met = (level === 3'h0);
      5: met = (sleeping === 1'b1);
      default: met = (main_en === 1'b0);
    endcase
  endfunction : met

  // bounded wait, cycle count returned
  task automatic wait_until(input int sel, input int lim, output int n);
    n = 0;
    while (!met(sel) && n < lim) begin
      @(negedge i_clk);
      n++;
    end
  endtask : wait_until

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    #100us;
    bad_count++;
    complete_run();
  end

  initial begin
    cycles(2);
    check({power_on_reset_n, early_reset_n, hard_reset_n, por_o, early_o, hard_o}, 6'h00);
    i_rstn = 1'b1;
    ign = 1'b1;
    cycles(4); // keep-alive low shorter than the filter, no fault
    check(main_en, 1'b0);
    ign = 1'b0;
    ka_ok = 1'b1;
    cycles(30);
    check(power_on_reset_n, 1'b0);
    wait_until(2, 100, cnt);
    check(power_on_reset_n, 1'b1);
    check(early_reset_n, 1'b0);
    ign = 1'b1;
    wait_until(0, 400, cnt);
    check({early_reset_n, hard_reset_n, discharge}, 3'h6);
    check(cnt >= 75, 1'b1);
    check(level, 3'h6);
    // short main glitch, then a lasting one
    bad = 3'h1;
    cycles(5);
    bad = 3'h0;
    cycles(10);
    check(early_reset_n, 1'b1);
    bad = 3'h1;
    wait_until(1, 40, cnt);
    check({early_reset_n, hard_reset_n, power_on_reset_n}, 3'h3);
    cycles(6);
    check(hard_reset_n, 1'b0);
    bad = 3'h0;
    wait_until(4, 300, cnt);
    check(level, 3'h0);
    wait_until(0, 600, cnt);
    check(early_reset_n, 1'b1);
    // keep-alive glitch, then a lasting fault together with a main fault
    ka_ok = 1'b0;
    cycles(5);
    ka_ok = 1'b1;
    cycles(10);
    check(power_on_reset_n, 1'b1);
    ka_ok = 1'b0;
    bad = 3'h4;
    wait_until(3, 40, cnt);
    check({power_on_reset_n, early_reset_n, hard_reset_n}, 3'h1);
    cycles(6);
    check(hard_reset_n, 1'b0);
    ka_ok = 1'b1;
    bad = 3'h0;
    cycles(30);
    check(power_on_reset_n, 1'b0);
    wait_until(0, 600, cnt);
    check({power_on_reset_n, early_reset_n}, 2'h3);
    // hold keeps supplies after ignition drops
    hold = 1'b1;
    ign = 1'b0;
    cycles(50);
    check({early_reset_n, aux_en}, 2'h3);
    hold = 1'b0;
    wait_until(1, 20, cnt);
    check(early_reset_n, 1'b0);
    wait_until(6, 300, cnt);
    check(main_en, 1'b0);
    // keep-alive fault while key off
    ka_ok = 1'b0;
    cycles(25);
    ka_ok = 1'b1;
    cycles(100);
    check(power_on_reset_n, 1'b0);
    ign = 1'b1;
    slow = 1'b1;
    wait_until(2, 150, cnt);
    check(power_on_reset_n, 1'b1);
    wait_until(0, 800, cnt);
    check(cnt >= 100, 1'b1);
    slow = 1'b0;
    // sleep while ignition active
    sleep_n = 1'b0;
    wait_until(5, 20, cnt);
    check(sleeping, 1'b1);
    wait_until(4, 300, cnt);
    check({level, early_reset_n, hard_reset_n}, 5'h03);
    sleep_n = 1'b1;
    wait_until(1, 20, cnt);
    check({early_reset_n, hard_reset_n}, 2'h0);
    wait_until(0, 600, cnt);
    check(early_reset_n, 1'b1);
    complete_run();
  end
endmodule : test_srs_supply_sequencer
